// [logic/scs_pkg.sv]
// Shared constants and types of the converter sequencer.
// Assumes one converter clock cycle per mclk edge.
package scs_pkg;

  // ----------------------------------------------------------
  // Widths
  // ----------------------------------------------------------
  localparam int RES_W = 12;
  localparam int CNT_W = 6;
  localparam int ACQ_W = 7;

  // ----------------------------------------------------------
  // Start source and input mux codes
  // ----------------------------------------------------------
  localparam logic [2:0] SRC_TMR0    = 3'h0;
  localparam logic [2:0] SRC_TMR1    = 3'h1;
  localparam logic [2:0] SRC_TMR2    = 3'h2;
  localparam logic [2:0] SRC_PIN     = 3'h4;
  localparam logic [2:0] SRC_PIN_INV = 3'h5;
  localparam logic [2:0] SRC_CONT    = 3'h6;
  localparam logic [2:0] SRC_BUSY    = 3'h7;
  localparam logic [2:0] MUX_REF     = 3'h5;

  // ----------------------------------------------------------
  // Phase lengths in converter clock cycles
  // ----------------------------------------------------------
  localparam int PWR_SE_CYC   = 10;
  localparam int ACQ_CYC      = 3;
  localparam int PWR_CONT_CYC = 8;
  localparam int CONT_TRK_CYC = 3;
  localparam int SETTLE_CYC   = 4;
  localparam int CONV_CYC     = 13;

  // ----------------------------------------------------------
  // Least track time in dual-edge mode
  // ----------------------------------------------------------
  localparam int CLK_NS       = 50;
  localparam int T_ACQ_OFF_NS = 2500;
  localparam int T_ACQ_ON_NS  = 1500;
  localparam int ACQ_OFF_CYC  = (T_ACQ_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_ON_CYC   = (T_ACQ_ON_NS + CLK_NS - 1) / CLK_NS;

  // Sequencer states, Gray coded along idle, power, track, settle, convert.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PWR    = 3'b001,
    ST_TRACK  = 3'b011,
    ST_SETTLE = 3'b010,
    ST_CONV   = 3'b110
  } scs_state_t;

endpackage

// [logic/scs_sync.sv]
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ns
module scs_sync (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// [logic/scs_seq.sv]
// Conversion sequencer for a 12-bit successive-approximation converter.
// Assumes the analog core follows power, hold and convert levels and
// presents its result on core_result by the last convert cycle.
`timescale 1ns/1ns
module scs_seq #(
  parameter int RES_W = scs_pkg::RES_W
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst,
  // Conversion start sources.
  input  wire logic             timer0_strobe,
  input  wire logic             timer1_strobe,
  input  wire logic             timer2_strobe,
  input  wire logic             external_trigger_pin,
  input  wire logic             start_busy_wr,
  // Configuration.
  input  wire logic [2:0]       start_source_select,
  input  wire logic             dual_edge_select,
  input  wire logic             auto_shutdown_en,
  input  wire logic [2:0]       input_mux_select,
  input  wire logic             ref_supply_select,
  input  wire logic             result_irq_enable,
  input  wire logic             global_irq_enable,
  input  wire logic             mask_bit_five,
  input  wire logic             result_flag_clear,
  // Analog core.
  input  wire logic [RES_W-1:0] core_result,
  output logic                  core_power_on,
  output logic                  core_hold,
  output logic                  core_convert,
  output logic [2:0]            core_mux_sel,
  output logic                  core_ref_supply,
  // Status.
  output logic [RES_W-1:0]      result_register,
  output logic                  result_ready_flag,
  output logic                  start_busy_bit,
  output logic                  track_short_flag,
  output logic                  data_ready_irq
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  localparam int CW = scs_pkg::CNT_W;
  localparam int AW = scs_pkg::ACQ_W;
  localparam logic [CW-1:0] LD_PWR_SE  = CW'(scs_pkg::PWR_SE_CYC - 1);
  localparam logic [CW-1:0] LD_PWR_CT  = CW'(scs_pkg::PWR_CONT_CYC - 1);
  localparam logic [CW-1:0] LD_TRK_CT  = CW'(scs_pkg::CONT_TRK_CYC - 1);
  localparam logic [CW-1:0] LD_SETTLE  = CW'(scs_pkg::SETTLE_CYC - 1);
  localparam logic [CW-1:0] LD_CONV    = CW'(scs_pkg::CONV_CYC - 1);
  localparam logic [AW-1:0] ACQ_MAX    = '1;
  localparam logic [AW-1:0] ACQ_LIM_OFF = AW'(scs_pkg::ACQ_OFF_CYC - 1);
  localparam logic [AW-1:0] ACQ_LIM_ON  = AW'(scs_pkg::ACQ_ON_CYC - 1);

  scs_pkg::scs_state_t st_r;
  scs_pkg::scs_state_t st_nxt;
  logic [CW-1:0]       cnt_r;
  logic [CW-1:0]       cnt_nxt;
  logic                mode_dual_r;
  logic                mode_dual_nxt;
  logic                mode_cont_r;
  logic                mode_cont_nxt;
  logic                powered_r;
  logic                powered_nxt;
  logic                strobe_r;
  logic                from_off_r;
  logic [AW-1:0]       acq_r;
  logic                pin_s;

  // ----------------------------------------------------------
  // Start strobe
  // ----------------------------------------------------------
  scs_sync u_pin_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (external_trigger_pin),
    .sync_out (pin_s)
  );

  // Source decode and the combined internal strobe.
  wire [2:0] sel      = start_source_select;
  wire       cont_sel = (sel == scs_pkg::SRC_CONT);
  wire       busy_sel = (sel == scs_pkg::SRC_BUSY);
  wire       edge_src = !cont_sel && !busy_sel;
  wire       tmr_lvl  = (sel == scs_pkg::SRC_TMR0) ? timer0_strobe :
                        (sel == scs_pkg::SRC_TMR1) ? timer1_strobe :
                        (sel == scs_pkg::SRC_TMR2) ? timer2_strobe : 1'b0;
  wire       pin_lvl  = (sel == scs_pkg::SRC_PIN_INV) ? ~pin_s : pin_s;
  wire       strobe_w = (sel == scs_pkg::SRC_PIN || sel == scs_pkg::SRC_PIN_INV) ? pin_lvl : tmr_lvl;
  wire       rise_w   = edge_src && strobe_w && !strobe_r;
  wire       fall_w   = edge_src && !strobe_w && strobe_r;

  // Edge classification by mode.
  // falling edge trigger
  wire se_trig  = (!dual_edge_select && fall_w) || (busy_sel && start_busy_wr);
  wire du_rise  = dual_edge_select && rise_w;
  wire du_fall  = dual_edge_select && fall_w;

  // State decode.
  wire idle_w   = (st_r == scs_pkg::ST_IDLE);
  wire trk_w    = (st_r == scs_pkg::ST_PWR) || (st_r == scs_pkg::ST_TRACK);
  wire cnt_z    = (cnt_r == '0);
  wire wr_w     = (st_r == scs_pkg::ST_CONV) && cnt_z;
  wire keep_cnt = mode_cont_r && cont_sel;
  wire irq_en_w = result_irq_enable && global_irq_enable && mask_bit_five;

  // Strobe history for edge detection.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= strobe_w;
    end
  end

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  // Next state and phase counter; each phase lasts its load plus one, except that in dual-edge mode the falling edge ends power or track.
  always_comb begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_z ? cnt_r : cnt_r - 1'b1;
    mode_dual_nxt = mode_dual_r;
    mode_cont_nxt = mode_cont_r;
    case (st_r)
      scs_pkg::ST_IDLE: begin
        if (cont_sel) begin
          mode_cont_nxt = 1'b1;
          mode_dual_nxt = 1'b0;
          st_nxt        = powered_r ? scs_pkg::ST_TRACK : scs_pkg::ST_PWR;
          cnt_nxt       = powered_r ? LD_TRK_CT : LD_PWR_CT;
        end else if (se_trig) begin
          mode_cont_nxt = 1'b0;
          mode_dual_nxt = 1'b0;
          st_nxt        = powered_r ? scs_pkg::ST_SETTLE : scs_pkg::ST_PWR;
          cnt_nxt       = powered_r ? LD_SETTLE : LD_PWR_SE;
        end else if (du_rise) begin
          mode_cont_nxt = 1'b0;
          mode_dual_nxt = 1'b1;
          st_nxt        = powered_r ? scs_pkg::ST_TRACK : scs_pkg::ST_PWR;
          cnt_nxt       = LD_PWR_SE;
        end
      end
      scs_pkg::ST_PWR: begin
        if (mode_dual_r && du_fall) begin
          st_nxt  = scs_pkg::ST_CONV;
          cnt_nxt = LD_CONV;
        end else if (cnt_z) begin
          if (!mode_dual_r && !mode_cont_r) begin
            st_nxt  = scs_pkg::ST_SETTLE;
            cnt_nxt = LD_SETTLE;
          end else begin
            st_nxt  = scs_pkg::ST_TRACK;
            cnt_nxt = LD_TRK_CT;
          end
        end
      end
      scs_pkg::ST_TRACK: begin
        if (mode_dual_r) begin
          if (du_fall) begin
            st_nxt  = scs_pkg::ST_CONV;
            cnt_nxt = LD_CONV;
          end
        end else if (cnt_z) begin
          st_nxt  = scs_pkg::ST_CONV;
          cnt_nxt = LD_CONV;
        end
      end
      scs_pkg::ST_SETTLE: begin
        if (cnt_z) begin
          st_nxt  = scs_pkg::ST_CONV;
          cnt_nxt = LD_CONV;
        end
      end
      scs_pkg::ST_CONV: begin
        if (cnt_z) begin
          st_nxt  = keep_cnt ? scs_pkg::ST_TRACK : scs_pkg::ST_IDLE;
          cnt_nxt = LD_TRK_CT;
        end
      end
      default: begin
        st_nxt  = scs_pkg::ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  // Power state: up after power phase, down after a result if auto shutdown is enabled, unless repeating.
  always_comb begin
    powered_nxt = powered_r;
    if (st_r == scs_pkg::ST_PWR && st_nxt != scs_pkg::ST_PWR) begin
      powered_nxt = 1'b1;
    end else if (wr_w && auto_shutdown_en && !keep_cnt) begin
      powered_nxt = 1'b0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r        <= scs_pkg::ST_IDLE;
      cnt_r       <= '0;
      mode_dual_r <= 1'b0;
      mode_cont_r <= 1'b0;
      powered_r   <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      mode_dual_r <= mode_dual_nxt;
      mode_cont_r <= mode_cont_nxt;
      powered_r   <= powered_nxt;
    end
  end

  // ----------------------------------------------------------
  // Dual-edge track time check
  // ----------------------------------------------------------
  // least track from off or on
  wire short_w = du_fall && mode_dual_r && trk_w &&
                 (acq_r < (from_off_r ? ACQ_LIM_OFF : ACQ_LIM_ON));

  // Counts track cycles from the rising edge; flags a too early falling edge.
  always_ff @(posedge mclk) begin
    if (rst) begin
      acq_r            <= '0;
      from_off_r       <= 1'b0;
      track_short_flag <= 1'b0;
    end else begin
      if (idle_w && du_rise && !cont_sel && !se_trig) begin
        acq_r      <= '0;
        from_off_r <= !powered_r;
      end else if (trk_w && acq_r != ACQ_MAX) begin
        acq_r <= acq_r + 1'b1;
      end
      track_short_flag <= short_w || (track_short_flag && !result_flag_clear);
    end
  end

  // ----------------------------------------------------------
  // Result, flag and interrupt
  // ----------------------------------------------------------
  // core ratio captured
  // global and mask gate
  // The setting edge beats a clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_register   <= '0;
      result_ready_flag <= 1'b0;
      data_ready_irq    <= 1'b0;
    end else begin
      if (wr_w) begin
        result_register <= core_result;
      end
      result_ready_flag <= wr_w || (result_ready_flag && !result_flag_clear);
      data_ready_irq    <= wr_w && irq_en_w;
    end
  end

  // Analog front-end selections follow configuration by one cycle.
  // reference to input
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_mux_sel    <= 3'h0;
      core_ref_supply <= 1'b0;
    end else begin
      core_mux_sel    <= input_mux_select;
      core_ref_supply <= ref_supply_select;
    end
  end

  // Core control levels decoded from the state.
  // busy whenever not idle
  assign start_busy_bit = !idle_w;
  assign core_power_on  = powered_r || (st_r == scs_pkg::ST_PWR);
  assign core_hold      = (st_r == scs_pkg::ST_SETTLE) || (st_r == scs_pkg::ST_CONV);
  assign core_convert   = (st_r == scs_pkg::ST_CONV);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wire se_go = idle_w && se_trig && !cont_sel;

  AST_CONT_PWR: assert property (
    (idle_w && cont_sel && !powered_r) |=> (st_r == scs_pkg::ST_PWR)[*8] ##1 (st_r == scs_pkg::ST_TRACK))
    else $error("continuous power-up is not eight cycles");

  AST_CONT_TRACK: assert property (
    ($rose(st_r == scs_pkg::ST_TRACK) && mode_cont_r) |-> !core_hold[*3] ##1 core_hold)
    else $error("continuous track is not three cycles");

  AST_CONT_PERIOD: assert property (
    (wr_w && keep_cnt) |-> ##16 wr_w)
    else $error("continuous period is not sixteen cycles");

  // Counts the cycles of the running conversion for the length check.
  logic [4:0] conv_len_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_len_r <= 5'h0;
    end else begin
      conv_len_r <= core_convert ? conv_len_r + 5'h1 : 5'h0;
    end
  end

  AST_CONV_LEN: assert property (
    $fell(core_convert) |-> (conv_len_r == 5'(scs_pkg::CONV_CYC)))
    else $error("conversion is not thirteen cycles");

  AST_HOLD_OFF: assert property (
    (se_go && !powered_r) |-> ##11 $rose(core_hold))
    else $error("hold not eleven cycles after start");

  AST_HOLD_ON: assert property (
    (se_go && powered_r) |=> core_hold)
    else $error("hold not immediate when powered");

  AST_SE_OFF: assert property (
    (se_go && !powered_r) |-> ##27 wr_w)
    else $error("result not 27 cycles after start");

  AST_SE_ON: assert property (
    (se_go && powered_r) |-> ##17 wr_w)
    else $error("result not 17 cycles after start");

  AST_DUAL_TRACK: assert property (
    (idle_w && du_rise && !cont_sel) |=> !core_hold && start_busy_bit)
    else $error("dual rising edge did not start track");

  AST_DUAL_CONV: assert property (
    (du_fall && mode_dual_r && trk_w) |-> ##13 wr_w)
    else $error("dual result not thirteen cycles after edge");

  AST_FLAG: assert property (
    wr_w |=> result_ready_flag && (result_register == $past(core_result)))
    else $error("result write did not set ready flag");

  AST_IRQ: assert property (
    data_ready_irq |-> $past(wr_w) && $past(irq_en_w))
    else $error("interrupt without result or enables");

  AST_BUSY: assert property (
    (wr_w && !keep_cnt) |=> !start_busy_bit)
    else $error("busy did not clear on result write");

  AST_MUX: assert property (
    (input_mux_select == scs_pkg::MUX_REF) |=> (core_mux_sel == scs_pkg::MUX_REF))
    else $error("reference not routed to input");

  COV_CONT: cover property (wr_w && keep_cnt ##16 wr_w);
  COV_SE_OFF: cover property (se_go && !powered_r ##27 wr_w);
  COV_DUAL: cover property (du_fall && mode_dual_r && trk_w ##13 wr_w);

endmodule

// [sim/scs_core_model.sv]
// Behavioural model of the analog track/hold and successive-approximation core.
// Assumes the sequencer's core_* levels on mclk; voltages are given in millivolts.
`timescale 1ns/1ns
module scs_core_model #(
  parameter int VIN_MV = 1000,
  parameter int REF_MV = 2500,
  parameter int SUP_MV = 3300
) (
  // Clock.
  input  wire logic        mclk,
  // Controls from the sequencer.
  input  wire logic        core_power_on,
  input  wire logic        core_convert,
  input  wire logic [2:0]  core_mux_sel,
  input  wire logic        core_ref_supply,
  // Conversion result.
  output logic [11:0]      core_result
);
  // ------------------------------------------------------------
  // Conversion
  // ------------------------------------------------------------
  logic [11:0] code_r;
  int          vin;
  int          vref;
  int          cnt;

  // input, reference and rounding
  // The code is frozen once conversion starts, as a real hold would.
  always @(posedge mclk) begin
    vin = (core_mux_sel == scs_pkg::MUX_REF) ? REF_MV : VIN_MV;
    vref = core_ref_supply ? SUP_MV : REF_MV;
    cnt = (4096 * vin + vref / 2) / vref;
    if (!core_convert) begin
      code_r <= (cnt > 4095) ? 12'hfff : cnt[11:0];
    end
  end

  // Outside a powered conversion the output is not valid, so it shows garbage.
  assign core_result = (core_convert && core_power_on) ? code_r : ~code_r;
endmodule

// [sim/scs_seq_tb.sv]
// Self-checking bench of the conversion sequencer.
// Assumes the core model of scs_core_model.sv and the design under logic/.
`timescale 1ns/1ns
module scs_seq_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int VIN_MV = 1000;
  localparam int REF_MV = 2500;
  localparam int SUP_MV = 3300;
  logic        mclk, rst, pin, wr, dual, ashd, rsel, ie, ge, m5, clr;
  logic [2:0]  tmr, src, mux, mux_o;
  logic [11:0] core_result, result_register, res_rdy;
  logic        pwr, hold, conv, ref_o, rdy, busy, short_f, irq, busy_rdy;
  int          mismatches, tests_run, th, tc, nc, tr, irq_seen;

  // Clock of 50 ns period.
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // ------------------------------------------------------------
  // Design and core model
  // ------------------------------------------------------------
  scs_seq u_scs_seq (.mclk(mclk), .rst(rst), .timer0_strobe(tmr[0]), .timer1_strobe(tmr[1]),
    .timer2_strobe(tmr[2]), .external_trigger_pin(pin), .start_busy_wr(wr),
    .start_source_select(src), .dual_edge_select(dual), .auto_shutdown_en(ashd),
    .input_mux_select(mux), .ref_supply_select(rsel), .result_irq_enable(ie),
    .global_irq_enable(ge), .mask_bit_five(m5), .result_flag_clear(clr),
    .core_result(core_result), .core_power_on(pwr), .core_hold(hold), .core_convert(conv),
    .core_mux_sel(mux_o), .core_ref_supply(ref_o), .result_register(result_register),
    .result_ready_flag(rdy), .start_busy_bit(busy), .track_short_flag(short_f),
    .data_ready_irq(irq));
  scs_core_model #(.VIN_MV(VIN_MV), .REF_MV(REF_MV), .SUP_MV(SUP_MV)) u_scs_core_model (
    .mclk(mclk), .core_power_on(pwr), .core_convert(conv), .core_mux_sel(mux_o),
    .core_ref_supply(ref_o), .core_result(core_result));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Clears the sticky flags so the next result can be timed.
  task automatic arm;
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask

  // One start/busy write pulse; watch lowers it at the edge that takes it.
  task automatic busy_write;
    arm;
    @(posedge mclk);
    wr <= 1'b1;
  endtask

  // Times hold, convert and ready against the rise of busy, bounded.
  task automatic watch;
    int b;
    b = -1;
    th = -1;
    tc = -1;
    nc = 0;
    tr = -1;
    irq_seen = 0;
    for (int i = 0; i < 150 && tr < 0; i++) begin
      @(posedge mclk);
      wr <= 1'b0;
      #1;
      if (b < 0 && busy === 1'b1) b = i;
      if (b >= 0) begin
        if (th < 0 && hold === 1'b1) th = i - b;
        if (tc < 0 && conv === 1'b1) tc = i - b;
        if (conv === 1'b1) nc++;
        if (irq === 1'b1) irq_seen = 1;
        if (rdy === 1'b1) begin
          tr = i - b;
          busy_rdy = busy;
          res_rdy = result_register;
        end
      end
    end
  endtask

  // Judges one timed conversion.
  task automatic expect_conv(input int eth, etc, etr, eirq, ecode, input logic ebusy);
    check(th, eth);
    check(tc, etc);
    check(nc, 13);
    check(tr, etr);
    check(irq_seen, eirq);
    check(busy_rdy, ebusy);
    check(res_rdy, ecode);
  endtask

  function automatic int code(input int vin, input int vref);
    int c;
    c = (4096 * vin + vref / 2) / vref;
    return (c > 4095) ? 4095 : c;
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Single-edge timer starts from shutdown, one per timer source.
  task automatic t_timers;
    for (int s = 0; s < 3; s++) begin
      @(posedge mclk);
      src <= s[2:0];
      arm;
      tmr <= 3'h1 << s;
      tick(3);
      tmr <= 3'h0;
      watch;
      expect_conv(10, 14, 27, 1, code(VIN_MV, REF_MV), 1'b0);
    end
    $display("done: timer starts");
  endtask

  // Start/busy writes, first from shutdown, then with the converter powered.
  task automatic t_busy;
    @(posedge mclk);
    src <= 3'h7;
    ashd <= 1'b0;
    busy_write;
    watch;
    expect_conv(10, 14, 27, 1, code(VIN_MV, REF_MV), 1'b0);
    busy_write;
    watch;
    expect_conv(0, 4, 17, 1, code(VIN_MV, REF_MV), 1'b0);
    $display("done: start/busy writes");
  endtask

  // Every combination of the three interrupt enables.
  task automatic t_irq;
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      {ie, ge, m5} <= k[2:0];
      busy_write;
      watch;
      expect_conv(0, 4, 17, (k == 7) ? 1 : 0, code(VIN_MV, REF_MV), 1'b0);
    end
    $display("done: interrupt enables");
  endtask

  // Dual-edge: rise only tracks, fall converts.
  task automatic t_dual;
    @(posedge mclk);
    dual <= 1'b1;
    ashd <= 1'b1;
    src <= 3'h1;
    arm;
    tmr <= 3'h2;
    // strobe held well past the least track time
    tick(60);
    #1;
    check(hold, 1'b0);
    check(busy, 1'b1);
    check(pwr, 1'b1);
    @(posedge mclk);
    tmr <= 3'h0;
    watch;
    check(tr - tc, 13);
    check(tc, th);
    check(res_rdy, code(VIN_MV, REF_MV));
    check(short_f, 1'b0);
    arm;
    tmr <= 3'h2;
    tick(6);
    tmr <= 3'h0;
    watch;
    check(tr - tc, 13);
    check(short_f, 1'b1);
    @(posedge mclk);
    dual <= 1'b0;
    $display("done: dual edge");
  endtask

  // Trigger pin, plain then inverted, single-edge from shutdown.
  task automatic t_pin;
    @(posedge mclk);
    pin <= 1'b1;
    src <= 3'h4;
    arm;
    tick(4);
    pin <= 1'b0;
    watch;
    expect_conv(10, 14, 27, 1, code(VIN_MV, REF_MV), 1'b0);
    @(posedge mclk);
    src <= 3'h5;
    arm;
    tick(4);
    pin <= 1'b1;
    watch;
    expect_conv(10, 14, 27, 1, code(VIN_MV, REF_MV), 1'b0);
    @(posedge mclk);
    src <= 3'h7;
    $display("done: trigger pin");
  endtask

  // Reference measured against the analog supply.
  task automatic t_mux;
    @(posedge mclk);
    mux <= scs_pkg::MUX_REF;
    rsel <= 1'b1;
    tick(3);
    #1;
    check(mux_o, scs_pkg::MUX_REF);
    check(ref_o, 1'b1);
    busy_write;
    watch;
    expect_conv(10, 14, 27, 1, code(REF_MV, SUP_MV), 1'b0);
    @(posedge mclk);
    mux <= 3'h0;
    rsel <= 1'b0;
    $display("done: reference measure");
  endtask

  // Continuous mode from shutdown, then the repeat period.
  task automatic t_cont;
    int n;
    arm;
    src <= 3'h6;
    watch;
    expect_conv(11, 11, 24, 1, code(VIN_MV, REF_MV), 1'b1);
    n = 0;
    for (int i = 1; i <= 40 && n == 0; i++) begin
      @(posedge mclk);
      #1;
      if (irq === 1'b1) n = i;
    end
    check(n, 16);
    @(posedge mclk);
    src <= 3'h7;
    n = 0;
    for (int i = 1; i <= 40 && n == 0; i++) begin
      @(posedge mclk);
      #1;
      if (busy === 1'b0) n = i;
    end
    check(n > 0, 1);
    $display("done: continuous");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {rst, pin, wr, dual, rsel, clr} = 6'h20;
    {ashd, ie, ge, m5} = 4'hf;
    tmr = 3'h0;
    src = 3'h7;
    mux = 3'h0;
    mismatches = 0;
    tests_run = 0;
    tick(12);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check({pwr, hold, conv, rdy, busy, irq, result_register}, 0);
    t_timers;
    t_busy;
    t_irq;
    t_dual;
    t_pin;
    t_mux;
    t_cont;
    close_out;
  end

  // Cuts a hang short well past the expected run of about 600 cycles.
  initial begin
    tick(8000);
    mismatches++;
    close_out;
  end
endmodule
